/* logic/fbgp_planner.v */
// Flash block group planner: splits a block range into aligned power-of-two groups
`timescale 1ns/1ps
`include "fbgp_defs.vh"

module fbgp_planner (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_req,
  input wire [`FBGP_BLK_W-1:0] i_start_block_index,
  input wire [`FBGP_BLK_W-1:0] i_last_block_index,
  input wire i_pass_done,
  output reg o_busy,
  output reg o_pass_valid,
  output reg [`FBGP_BLK_W-1:0] o_pass_start,
  output reg [`FBGP_SIZE_W-1:0] o_group_size,
  output reg [`FBGP_PASS_W-1:0] o_group_pass_count,
  output reg o_done
);

  // Reset synchroniser flops
  reg rst_meta_b;
  reg rst_sync_b;

  // Sequencer state and its next value
  reg [1:0] state;
  reg [1:0] next_state;

  // Working range; remaining is one bit wider to hold a full 64K span
  reg [`FBGP_BLK_W-1:0] start_block_index;
  reg [`FBGP_BLK_W-1:0] next_start_block_index;
  reg [`FBGP_BLK_W:0] remaining_block_count;
  reg [`FBGP_BLK_W:0] next_remaining_block_count;

  // Next values of the registered outputs
  reg next_busy;
  reg next_pass_valid;
  reg [`FBGP_BLK_W-1:0] next_pass_start;
  reg [`FBGP_SIZE_W-1:0] next_group_size;
  reg [`FBGP_PASS_W-1:0] next_group_pass_count;
  reg next_done;

  // Candidate tests and the chosen group size
  wire [`FBGP_SIZE_W-1:0] candidate_ok;
  reg [`FBGP_SIZE_W-1:0] group_size;
  wire accept;
  integer k;

  // Size of the candidate with the given power-of-two index
  function [`FBGP_SIZE_W-1:0] fbgp_size_of;
    input integer lg;
    begin
      fbgp_size_of = `FBGP_ONE_SIZE << lg;
    end
  endfunction

  // True when the low lg bits of a block index are all zero
  function fbgp_aligned;
    input [`FBGP_BLK_W-1:0] idx;
    input integer lg;
    reg [`FBGP_BLK_W-1:0] mask;
    begin
      mask = (`FBGP_ONE_BLK << lg) - `FBGP_ONE_BLK;
      fbgp_aligned = ((idx & mask) == `FBGP_ZERO_BLK);
    end
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `FBGP_NSIZES; g = g + 1) begin : g_cand
      assign candidate_ok[g] =
        (remaining_block_count >= {1'b0, `FBGP_ZERO_SIZE, fbgp_size_of(g)}) &&
        fbgp_aligned(start_block_index, g);
    end
  endgenerate

  // largest allowed size
  // Later (larger) candidates override smaller ones, so no priority encoder needed
  always @* begin
    group_size = `FBGP_ZERO_SIZE;
    for (k = 0; k < `FBGP_NSIZES; k = k + 1) begin
      if (candidate_ok[k]) begin
        group_size = fbgp_size_of(k);
      end
    end
  end

  // Request taken only in idle with a forward range
  assign accept = (state == `FBGP_ST_IDLE) && i_req &&
                  (i_last_block_index >= i_start_block_index);

  // Next-state logic; one group outstanding at a time so pass times add up
  always @* begin
    next_state = state;
    next_start_block_index = start_block_index;
    next_remaining_block_count = remaining_block_count;
    next_busy = o_busy;
    next_pass_valid = 1'b0; // Pulse only
    next_pass_start = o_pass_start;
    next_group_size = o_group_size;
    next_group_pass_count = o_group_pass_count;
    next_done = o_done;
    case (state)
      `FBGP_ST_IDLE: begin
        // Reversed ranges are refused; outputs stay as they were
        if (accept) begin
          next_start_block_index = i_start_block_index;
          next_remaining_block_count =
            {1'b0, i_last_block_index - i_start_block_index} + `FBGP_ONE_REM;
          next_group_pass_count = `FBGP_ZERO_PASS;
          next_done = 1'b0;
          next_busy = 1'b1;
          next_state = `FBGP_ST_PICK;
        end
      end
      `FBGP_ST_PICK: begin
        if (remaining_block_count == `FBGP_ZERO_REM) begin
          next_done = 1'b1;
          next_busy = 1'b0;
          next_state = `FBGP_ST_IDLE;
        end else begin
          next_state = `FBGP_ST_ISSUE;
        end
      end
      `FBGP_ST_ISSUE: begin
        next_pass_valid = 1'b1;
        next_pass_start = start_block_index;
        next_group_size = group_size;
        next_group_pass_count = o_group_pass_count + `FBGP_ONE_PASS;
        next_state = `FBGP_ST_WAIT;
      end
      `FBGP_ST_WAIT: begin
        // wait for array
        // A done pulse seen outside this state is ignored
        if (i_pass_done) begin
          next_start_block_index = start_block_index + {`FBGP_ZERO_SIZE, o_group_size};
          next_remaining_block_count =
            remaining_block_count - {1'b0, `FBGP_ZERO_SIZE, o_group_size};
          next_state = `FBGP_ST_PICK;
        end
      end
      default: begin
        next_state = `FBGP_ST_IDLE;
      end
    endcase
  end

  // State and output registers
  always @(posedge i_sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= `FBGP_ST_IDLE;
      start_block_index <= `FBGP_ZERO_BLK;
      remaining_block_count <= `FBGP_ZERO_REM;
      o_busy <= 1'b0;
      o_pass_valid <= 1'b0;
      o_pass_start <= `FBGP_ZERO_BLK;
      o_group_size <= `FBGP_ZERO_SIZE;
      o_group_pass_count <= `FBGP_ZERO_PASS;
      o_done <= 1'b0;
    end else begin
      state <= next_state;
      start_block_index <= next_start_block_index;
      remaining_block_count <= next_remaining_block_count;
      o_busy <= next_busy;
      o_pass_valid <= next_pass_valid;
      o_pass_start <= next_pass_start;
      o_group_size <= next_group_size;
      o_group_pass_count <= next_group_pass_count;
      o_done <= next_done;
    end
  end

endmodule // fbgp_planner

/* logic/fbgp_defs.vh */
// Constants for the flash block group planner
`ifndef FBGP_DEFS_VH
`define FBGP_DEFS_VH
`define FBGP_BLK_W 16
`define FBGP_SIZE_W 8
`define FBGP_NSIZES 8
`define FBGP_PASS_W 16
`define FBGP_ST_IDLE 2'h0
`define FBGP_ST_PICK 2'h1
`define FBGP_ST_ISSUE 2'h2
`define FBGP_ST_WAIT 2'h3
`define FBGP_ZERO_BLK 16'h0000
`define FBGP_ZERO_SIZE 8'h00
`define FBGP_ZERO_PASS 16'h0000
`define FBGP_ONE_PASS 16'h0001
`define FBGP_ZERO_REM 17'h00000
`define FBGP_ONE_REM 17'h00001
`define FBGP_ONE_BLK 16'h0001
`define FBGP_ONE_SIZE 8'h01
`endif

/* testbench/fbgp_flash_model.sv */
// Flash array model answering each issued group
`timescale 1ns/1ps
module fbgp_flash(input wire i_clk, i_go, input wire [3:0] i_lat, output reg o_done = 0);
  always @(posedge i_clk) if (i_go) begin
    repeat (i_lat + 1) @(posedge i_clk);
    o_done <= 1;
    @(posedge i_clk) o_done <= 0;
  end
endmodule // fbgp_flash

/* testbench/fbgp_planner_assertions.sv */
// Port checker for the group planner
`timescale 1ns/1ps
module fbgp_chk(input wire i_sys_clk, i_rst_b, i_req, i_pass_done, o_busy, o_pass_valid, o_done,
  input wire [15:0] i_last_block_index, o_pass_start, o_group_pass_count,
  input wire [7:0] o_group_size);
  reg [15:0] lst, nx;
  wire [15:0] s = o_pass_start;
  wire [15:0] g = o_group_size;
  wire [16:0] top = s + g - 1;
  // Range end and expected next start
  always @(posedge i_sys_clk) begin
    if (i_req && !o_busy) lst <= i_last_block_index;
    if (o_pass_valid) nx <= s + g;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_last; i_pass_done && o_busy && top == lst; endsequence
  a_size_pow2: assert property (o_pass_valid |-> $onehot(o_group_size)) else $error("size");
  a_group_align: assert property (o_pass_valid |-> (s & (g - 1)) == 0) else $error("align");
  a_group_fits: assert property (o_pass_valid |-> top <= lst) else $error("overrun");
  a_size_largest: assert property (o_pass_valid && g < 128 |->
    (s & (2 * g - 1)) != 0 || top + g > lst) else $error("not largest");
  a_start_adv: assert property (o_pass_valid && o_group_pass_count > 1 |-> s == nx)
    else $error("advance");
  a_count_step: assert property (o_pass_valid |->
    o_group_pass_count == $past(o_group_pass_count) + 1) else $error("count");
  a_done_end: assert property (s_last |-> ##[1:2] o_done && !o_busy) else $error("done");
  a_count_hold: assert property (o_done && !i_req |=> $stable(o_group_pass_count))
    else $error("hold");
endmodule // fbgp_chk
bind fbgp_planner fbgp_chk u_chk(.*);

/* testbench/tb.sv */
// Self-checking bench for the group planner
`timescale 1ns/1ps
module tb;
  reg i_sys_clk = 0, i_rst_b = 0, i_req = 0;
  reg [15:0] i_start_block_index = 0, i_last_block_index = 0, sd = 16'hADF2;
  reg [3:0] lat = 0;
  wire i_pass_done, o_busy, o_pass_valid, o_done;
  wire [15:0] o_pass_start, o_group_pass_count;
  wire [7:0] o_group_size;
  logic [23:0] q[$];
  int mismatches = 0, num_checks = 0, n, k;
  fbgp_planner dut(.*);
  fbgp_flash fl(.i_clk(i_sys_clk), .i_go(o_pass_valid), .i_lat(lat), .o_done(i_pass_done));
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  function [15:0] lf(input [15:0] v);
    lf = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task cmp(input [23:0] a, b);
    num_checks++;
    if (a !== b) begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, a, b);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Oldest note taken per issued group
  always @(negedge i_sys_clk) if (o_pass_valid === 1'b1) cmp({o_pass_start, o_group_size},
    q.pop_front());
  // Notes every group, then requests the range
  task run(input [15:0] a, b);
    int st, r, g;
    st = a;
    r = b - a + 1;
    n = 0;
    while (r > 0) begin
      for (g = 128; g > r || st % g; g = g / 2);
      q.push_back({st[15:0], g[7:0]});
      st += g;
      r -= g;
      n++;
    end
    i_req <= 1;
    i_start_block_index <= a;
    i_last_block_index <= b;
    @(posedge i_sys_clk) i_req <= 0;
    repeat (3) @(posedge i_sys_clk);
    for (k = 0; k < 4000 && o_done !== 1'b1; k++) @(posedge i_sys_clk);
    if (k >= 4000) mismatches++;
    if (b < a) cmp(o_busy, 0);
    else cmp(o_group_pass_count, n);
    $display("test %0d %0d end", a, b);
  endtask
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1;
    repeat (3) @(posedge i_sys_clk);
    run(1, 127);
    run(5, 10);
    run(0, 0);
    run(256, 511);
    run(9, 3);
    repeat (6) begin
      sd = lf(sd);
      lat <= sd[3:0];
      run(sd[7:0], sd[7:0] + sd[13:8]);
    end
    final_report;
  end
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
endmodule // tb
